// file: csm_regs.sv
// module: AXI4-Lite register bank for converter sleep voltage, mode and disable controls
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
// Contract
// RULE1 - rail3 sleep register holds a 7-bit sleep code in bits 7:1, used only during sleep.
// RULE2 - rail3 sleep enable bit 0: 0 always normal code, 1 sleep code while its pin is low.
// RULE3 - each rail's sleep input is fixed at build time to sleep input 1 or sleep input 2.
// RULE4 - rails 4-6 sleep field 5:4: 00 always normal, 11 sleep while the assigned pin is low.
// RULE5 - host never writes 01 or 10 into a rail 4-6 sleep field.
// RULE6 - rail 4-6 bits 3:2 are read/write, reset to 11, and host always writes 11.
// RULE7 - rails 4 and 5 bit 1 selects forced PWM at 1; host keeps it at 1.
// RULE8 - rail6 bit 1 gives automatic mode at 0 and forced PWM at 1, applied to the converter.
// RULE9 - rails 4-6 bit 0 at 0 forces the rail off whatever the enable pins say.
// RULE10 - rail 4, 5, 6 controls decode at 25h, 26h, 27h with bits 7:6 read-only.
// RULE11 - rail3 normal code sits in bits 7:1 at 23h and is the target outside sleep.
// RULE12 - unset fields load from the chosen config bank; pin high returns to normal code.
module csm_regs #(
  // per rail 3..6 (bit 0 = rail 3): 0 = sleep input 1, 1 = sleep input 2
  parameter logic [3:0] SLEEP_PIN_ASSIGN = 4'h0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [csm_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [csm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [csm_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [csm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // nonvolatile configuration banks
  input wire csm_pkg::csm_nvm_t nvm_bank0,
  input wire csm_pkg::csm_nvm_t nvm_bank1,
  input wire logic nvm_bank_sel,
  // control pins, active-low sleep inputs
  input wire logic ctrl_pin3_sleep_input1_n,
  input wire logic ctrl_pin6_sleep_input2_n,
  input wire logic [2:0] rail_enable_pins,
  // converter controls
  output logic [6:0] rail3_target_code,
  output logic rail3_in_sleep,
  output csm_pkg::csm_rail_out_t [2:0] rail_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [6:0] rail3_normal_voltage_code_r;
  logic [6:0] rail3_sleep_voltage_code_r;
  logic rail3_sleep_enable_r;
  csm_pkg::csm_rail_ctrl_t [2:0] rail_ctrl_r;
  logic load_r;
  csm_pkg::csm_nvm_t nvm_sel;

  // bus state
  csm_pkg::csm_wr_state_t wst_r;
  csm_pkg::csm_rd_state_t rst_r;
  logic aw_have_r;
  logic w_have_r;
  logic [5:0] aw_idx_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic commit;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic [7:0] rd_byte;
  logic [3:0] sleep_pin_low;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx >= csm_pkg::IDX_RAIL3_NORMAL) && (idx <= csm_pkg::IDX_RAIL6);
  endfunction

  // handshakes and merged write request
  always_comb begin
    aw_hs = awvalid && awready;
    w_hs = wvalid && wready;
    ar_hs = arvalid && arready;
    wr_idx = aw_have_r ? aw_idx_r : awaddr[7:csm_pkg::IDX_LSB];
    wr_byte = w_have_r ? wbyte_r : wdata[7:0];
    wr_lane = w_have_r ? wlane_r : wstrb[0];
    commit = (wst_r == csm_pkg::WR_IDLE) && (aw_have_r || aw_hs) && (w_have_r || w_hs);
    wr_en = commit && wr_lane; // lanes 1..3 carry no bits
    rd_idx = araddr[7:csm_pkg::IDX_LSB];
    nvm_sel = nvm_bank_sel ? nvm_bank1 : nvm_bank0;
  end

  // fixed factory routing of the sleep inputs
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (SLEEP_PIN_ASSIGN[k] == csm_pkg::PIN_SEL_INPUT1) begin
        sleep_pin_low[k] = !ctrl_pin3_sleep_input1_n; // RULE3
      end else begin
        sleep_pin_low[k] = !ctrl_pin6_sleep_input2_n; // RULE3
      end
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile load
  // ----------------------------------------------------------------
  // one load cycle right after release; the bus stays not-ready meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_r <= 1'b1;
    end else begin
      load_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // rail3 voltage registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail3_normal_voltage_code_r <= csm_pkg::CODE_RESET;
      rail3_sleep_voltage_code_r <= csm_pkg::CODE_RESET;
      rail3_sleep_enable_r <= 1'b0;
    end else if (load_r) begin
      rail3_normal_voltage_code_r <= nvm_sel.rail3_normal.code; // RULE12
      rail3_sleep_voltage_code_r <= nvm_sel.rail3_sleep.code; // RULE12
      rail3_sleep_enable_r <= nvm_sel.rail3_sleep.flag; // RULE12
    end else if (wr_en) begin
      if (wr_idx == csm_pkg::IDX_RAIL3_NORMAL) begin
        rail3_normal_voltage_code_r <= wr_byte[7:1]; // RULE11
      end
      if (wr_idx == csm_pkg::IDX_RAIL3_SLEEP) begin
        rail3_sleep_voltage_code_r <= wr_byte[7:1]; // RULE1
        rail3_sleep_enable_r <= wr_byte[0]; // RULE2
      end
    end
  end

  // ----------------------------------------------------------------
  // rail 4..6 control registers
  // ----------------------------------------------------------------
  // reserved 3:2 start at 11 and are never taken from the bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < csm_pkg::NUM_RAILS; i++) begin
        rail_ctrl_r[i].rsvd_ro <= csm_pkg::RSVD_RO_VALUE;
        rail_ctrl_r[i].sleep_en <= csm_pkg::SLEEP_EN_OFF;
        rail_ctrl_r[i].rsvd_wr <= csm_pkg::RSVD_WR_RESET; // RULE6
        rail_ctrl_r[i].mode <= csm_pkg::MODE_FPWM;
        rail_ctrl_r[i].enable <= csm_pkg::RAIL_OFF;
      end
    end else if (load_r) begin
      for (int i = 0; i < csm_pkg::NUM_RAILS; i++) begin
        rail_ctrl_r[i].sleep_en <= nvm_sel.rail[i].sleep_en; // RULE12
        rail_ctrl_r[i].mode <= nvm_sel.rail[i].mode; // RULE12
        rail_ctrl_r[i].enable <= nvm_sel.rail[i].enable; // RULE12
      end
    end else if (wr_en) begin
      for (int i = 0; i < csm_pkg::NUM_RAILS; i++) begin
        if (wr_idx == csm_pkg::IDX_RAIL4 + 6'(i)) begin // RULE10
          // reserved codes are stored as written and simply never select sleep
          rail_ctrl_r[i].sleep_en <= wr_byte[5:4]; // RULE4
          rail_ctrl_r[i].rsvd_wr <= wr_byte[3:2]; // RULE6
          rail_ctrl_r[i].mode <= wr_byte[1]; // RULE7
          rail_ctrl_r[i].enable <= wr_byte[0]; // RULE9
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // converter outputs
  // ----------------------------------------------------------------
  // rail3 target: sleep code only while enabled and its pin is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail3_target_code <= csm_pkg::CODE_RESET;
      rail3_in_sleep <= 1'b0;
    end else if (rail3_sleep_enable_r && sleep_pin_low[0]) begin
      rail3_target_code <= rail3_sleep_voltage_code_r; // RULE1
      rail3_in_sleep <= 1'b1; // RULE2
    end else begin
      rail3_target_code <= rail3_normal_voltage_code_r; // RULE11
      rail3_in_sleep <= 1'b0; // RULE12
    end
  end

  // rails 4..6: sleep select, mode and gated enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail_out <= '0;
    end else begin
      for (int i = 0; i < csm_pkg::NUM_RAILS; i++) begin
        rail_out[i].sleep_sel <= (rail_ctrl_r[i].sleep_en == csm_pkg::SLEEP_EN_ON)
          && sleep_pin_low[i+1]; // RULE4
        rail_out[i].forced_pwm <= rail_ctrl_r[i].mode; // RULE8
        // disable bit wins over the pin sequencer
        rail_out[i].enable <= rail_enable_pins[i] && rail_ctrl_r[i].enable; // RULE9
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data may arrive in either order; each is parked until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= csm_pkg::WR_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= '0;
      wbyte_r <= csm_pkg::BYTE_ZERO;
      wlane_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= csm_pkg::RESP_OKAY;
    end else begin
      unique case (wst_r)
        csm_pkg::WR_IDLE: begin
          if (aw_hs) begin
            aw_idx_r <= awaddr[7:csm_pkg::IDX_LSB];
          end
          if (w_hs) begin
            wbyte_r <= wdata[7:0];
            wlane_r <= wstrb[0];
          end
          if (commit) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b1;
            bresp <= idx_mapped(wr_idx) ? csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR;
            wst_r <= csm_pkg::WR_RESP;
          end else begin
            aw_have_r <= aw_have_r || aw_hs;
            w_have_r <= w_have_r || w_hs;
            awready <= !(aw_have_r || aw_hs) && !load_r;
            wready <= !(w_have_r || w_hs) && !load_r;
          end
        end
        csm_pkg::WR_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            wst_r <= csm_pkg::WR_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // read view; bits 7:6 of rail controls and bit 0 at 23h read as zero
  always_comb begin
    rd_byte = csm_pkg::BYTE_ZERO;
    unique case (rd_idx)
      csm_pkg::IDX_RAIL3_NORMAL: rd_byte = {rail3_normal_voltage_code_r, 1'b0}; // RULE11
      csm_pkg::IDX_RAIL3_SLEEP: rd_byte = {rail3_sleep_voltage_code_r, rail3_sleep_enable_r};
      csm_pkg::IDX_RAIL4: rd_byte = rail_ctrl_r[0]; // RULE10
      csm_pkg::IDX_RAIL5: rd_byte = rail_ctrl_r[1]; // RULE10
      csm_pkg::IDX_RAIL6: rd_byte = rail_ctrl_r[2]; // RULE10
      default: rd_byte = csm_pkg::BYTE_ZERO;
    endcase
  end

  // one read at a time; data are latched so they hold while rvalid waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r <= csm_pkg::RD_IDLE;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= csm_pkg::RESP_OKAY;
    end else begin
      unique case (rst_r)
        csm_pkg::RD_IDLE: begin
          if (ar_hs) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= idx_mapped(rd_idx) ? csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR;
            rst_r <= csm_pkg::RD_DATA;
          end else begin
            arready <= !load_r;
          end
        end
        csm_pkg::RD_DATA: begin
          if (rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
            rst_r <= csm_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  rail3_sleep_code_a: assert property ( // RULE1
    (rail3_sleep_enable_r && sleep_pin_low[0]) |=>
      (rail3_target_code == $past(rail3_sleep_voltage_code_r)) && rail3_in_sleep)
    else $error("rail3 sleep code not applied");

  rail3_normal_code_a: assert property ( // RULE2
    !rail3_sleep_enable_r |=>
      (rail3_target_code == $past(rail3_normal_voltage_code_r)) && !rail3_in_sleep)
    else $error("rail3 left normal code with sleep disabled");

  sleep_exit_a: assert property ( // RULE12
    $rose(ctrl_pin3_sleep_input1_n) && (SLEEP_PIN_ASSIGN[0] == csm_pkg::PIN_SEL_INPUT1)
      && !$past(load_r) |=> !rail3_in_sleep)
    else $error("rail3 stayed in sleep after pin went high");

  rail_sleep_off_a: assert property ( // RULE4
    (rail_ctrl_r[1].sleep_en != csm_pkg::SLEEP_EN_ON) |=> !rail_out[1].sleep_sel)
    else $error("rail5 entered sleep without enable code 11");

  rail_disable_a: assert property ( // RULE9
    (rail_ctrl_r[2].enable == csm_pkg::RAIL_OFF) |=> !rail_out[2].enable)
    else $error("rail6 on while disabled");

  rail6_mode_a: assert property ( // RULE8
    aresetn |=> rail_out[2].forced_pwm == $past(rail_ctrl_r[2].mode))
    else $error("rail6 mode not applied");

  rail4_mode_a: assert property ( // RULE7
    aresetn |=> rail_out[0].forced_pwm == $past(rail_ctrl_r[0].mode))
    else $error("rail4 mode not applied");

  reserved_read_a: assert property ( // RULE10
    $rose(rvalid) |-> (rdata[31:6] == '0) || (rresp == csm_pkg::RESP_OKAY
      && $past(rd_idx) <= csm_pkg::IDX_RAIL3_SLEEP))
    else $error("read-only reserved bits not zero");

  reserved_reset_a: assert property ( // RULE6
    $fell(load_r) |-> rail_ctrl_r[1].rsvd_wr == csm_pkg::RSVD_WR_RESET)
    else $error("reserved bits 3:2 lost reset value");

  write_resp_a: assert property ( // RULE10
    commit |=> bvalid ##0 (bresp == (idx_mapped($past(wr_idx)) ?
      csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR)))
    else $error("write response missing or wrong");

  write_done_c: cover property (commit ##1 bvalid && bready);
  read_done_c: cover property (ar_hs ##1 rvalid && rready);
  rail3_sleep_c: cover property (!rail3_in_sleep ##1 rail3_in_sleep);
  rail_off_c: cover property (rail_enable_pins[0] && !rail_ctrl_r[0].enable);

endmodule

// file: csm_pkg.sv
// package: register map, field layouts and state codes of the rail sleep/mode registers
package csm_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_RAIL3_NORMAL = 6'h23;
  localparam logic [5:0] IDX_RAIL3_SLEEP = 6'h24;
  localparam logic [5:0] IDX_RAIL4 = 6'h25;
  localparam logic [5:0] IDX_RAIL5 = 6'h26;
  localparam logic [5:0] IDX_RAIL6 = 6'h27;
  localparam int NUM_RAILS = 3;

  // ----------------------------------------------------------------
  // field values
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SLEEP_EN_OFF = 2'h0;
  localparam logic [1:0] SLEEP_EN_ON = 2'h3;
  localparam logic [1:0] RSVD_WR_RESET = 2'h3;
  localparam logic [1:0] RSVD_RO_VALUE = 2'h0;
  localparam logic MODE_AUTO = 1'h0;
  localparam logic MODE_FPWM = 1'h1;
  localparam logic RAIL_OFF = 1'h0;
  localparam logic PIN_SEL_INPUT1 = 1'h0;
  localparam logic [6:0] CODE_RESET = 7'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // rail3 voltage register: code in 7:1, flag in 0
  typedef struct packed {
    logic [6:0] code;
    logic flag;
  } csm_vid_reg_t;

  // rail 4..6 control register layout
  typedef struct packed {
    logic [1:0] rsvd_ro;
    logic [1:0] sleep_en;
    logic [1:0] rsvd_wr;
    logic mode;
    logic enable;
  } csm_rail_ctrl_t;

  // one nonvolatile configuration bank; rail[0] is rail 4
  typedef struct packed {
    csm_vid_reg_t rail3_normal;
    csm_vid_reg_t rail3_sleep;
    csm_rail_ctrl_t [2:0] rail;
  } csm_nvm_t;

  // converter-facing controls of rails 4..6
  typedef struct packed {
    logic sleep_sel;
    logic forced_pwm;
    logic enable;
  } csm_rail_out_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } csm_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } csm_rd_state_t;

endpackage

// file: csm_host.sv
// host-side model: AXI4-Lite master issuing register writes and reads
`timescale 1ns/1ns
module csm_host (
  // clock
  input wire logic aclk,
  // write address and data
  output logic [csm_pkg::ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [csm_pkg::DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  // write response
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [csm_pkg::ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [csm_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ----------------------------------------------------------------
  // idle bus and transfer tasks
  // ----------------------------------------------------------------
  // all requests idle at time zero
  initial begin
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // rail byte: reserved 3:2 always 11, read-only 7:6 left 0
  function automatic logic [7:0] rail_byte(input logic [1:0] sl, input logic md,
                                           input logic en);
    rail_byte = {2'h0, sl, 2'h3, md, en};
  endfunction

  // address and data offered together; each dropped once taken, no cycle count assumed
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] strb,
                    output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask

  // read: rready held up until the data is sampled
  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

// file: converter_sleep_mode_ctrl_regs_test.sv
// self-checking bench for the rail sleep, mode and disable register bank
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module converter_sleep_mode_ctrl_regs_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, bank_sel, pin1_n, pin2_n, in_sleep;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] en_pins;
  logic [6:0] target;
  csm_pkg::csm_nvm_t nvm0, nvm1;
  csm_pkg::csm_rail_out_t [2:0] rail_out;
  int failures = 0;
  int check_count = 0;
  // unmapped indices at both ends of the map
  logic [5:0] idx_tab [7] = '{6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28};
  logic [7:0] rd_tab [7] = '{8'h00, 8'h22, 8'h45, 8'h3F, 8'h3F, 8'h0D, 8'h00};

  // 25 MHz clock
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // rail 4 and 6 follow sleep input 2, rails 3 and 5 sleep input 1
  csm_regs #(.SLEEP_PIN_ASSIGN(4'hA)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .nvm_bank0(nvm0), .nvm_bank1(nvm1), .nvm_bank_sel(bank_sel),
    .ctrl_pin3_sleep_input1_n(pin1_n), .ctrl_pin6_sleep_input2_n(pin2_n),
    .rail_enable_pins(en_pins), .rail3_target_code(target),
    .rail3_in_sleep(in_sleep), .rail_out(rail_out)
  );

  csm_host u_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // write, then read back and compare
  task automatic wrc(input logic [5:0] idx, input logic [7:0] wd, input logic [7:0] exp);
    logic [1:0] resp;
    logic [31:0] rd;
    u_host.wr(idx, wd, 4'hF, resp);
    `CHK(resp, csm_pkg::RESP_OKAY)
    u_host.rd(idx, rd, resp);
    `CHK(rd, {24'h0, exp})
  endtask

  // converter outputs settle one edge after register or pin; allow margin
  task automatic outs(input logic [6:0] t, input logic s, input logic [8:0] r);
    repeat (3) @(posedge aclk);
    `CHK(target, t)
    `CHK(in_sleep, s)
    `CHK(rail_out, r)
  endtask

  task automatic complete_run;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs little more than a hundred cycles
  initial begin
    repeat (4000) @(posedge aclk);
    failures++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] resp;
    logic [31:0] rd;
    aresetn = 1'b0;
    pin1_n = 1'b1;
    pin2_n = 1'b1;
    en_pins = 3'h7;
    bank_sel = 1'b1;
    nvm0 = '0;
    nvm1 = {8'h23, 8'h45, 8'h01, 8'h33, 8'hFF};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    outs(7'h11, 1'b0, 9'h05B);
    // bank values, read-only 7:6 cleared, 3:2 kept at 11, unmapped refused
    for (int i = 0; i < 7; i++) begin
      u_host.rd(idx_tab[i], rd, resp);
      `CHK(rd, {24'h0, rd_tab[i]})
      `CHK(resp, (i == 0 || i == 6) ? csm_pkg::RESP_SLVERR : csm_pkg::RESP_OKAY)
    end
    u_host.wr(6'h28, 8'hFF, 4'hF, resp);
    `CHK(resp, csm_pkg::RESP_SLVERR)
    // sleep input 1 low: rail 3 and rail 5 go to sleep
    @(posedge aclk);
    pin1_n <= 1'b0;
    outs(7'h22, 1'b1, 9'h07B);
    // swap to sleep input 2: rail 3 back to normal, rail 4 sleeps
    @(posedge aclk);
    pin1_n <= 1'b1;
    pin2_n <= 1'b0;
    outs(7'h11, 1'b0, 9'h05F);
    @(posedge aclk);
    pin2_n <= 1'b1;
    pin1_n <= 1'b0;
    wrc(6'h24, 8'h44, 8'h44);
    outs(7'h11, 1'b0, 9'h07B);
    wrc(6'h23, 8'h31, 8'h30);
    outs(7'h18, 1'b0, 9'h07B);
    // byte lane 0 not strobed: accepted but nothing is stored
    u_host.wr(6'h23, 8'hFE, 4'hE, resp);
    `CHK(resp, csm_pkg::RESP_OKAY)
    u_host.rd(6'h23, rd, resp);
    `CHK(rd, 32'h00000030)
    @(posedge aclk);
    pin1_n <= 1'b1;
    wrc(6'h27, u_host.rail_byte(2'h0, 1'b1, 1'b1), 8'h0F);
    outs(7'h18, 1'b0, 9'h0DB);
    wrc(6'h27, u_host.rail_byte(2'h0, 1'b1, 1'b0), 8'h0E);
    outs(7'h18, 1'b0, 9'h09B);
    @(posedge aclk);
    en_pins <= 3'h6;
    outs(7'h18, 1'b0, 9'h09A);
    wrc(6'h25, 8'hFF, 8'h3F);
    wrc(6'h26, u_host.rail_byte(2'h0, 1'b1, 1'b1), 8'h0F);
    @(posedge aclk);
    pin1_n <= 1'b0;
    outs(7'h18, 1'b0, 9'h09A);
    // mid-run reset with bank 0 chosen: bank-loaded fields reload, bits 3:2 back to 11
    @(posedge aclk);
    aresetn <= 1'b0;
    bank_sel <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    outs(7'h00, 1'b0, 9'h000);
    u_host.rd(6'h27, rd, resp);
    `CHK(rd, 32'h0000000C)
    complete_run();
  end
endmodule
